/* File: plc_defs.svh */
// Offsets, field positions, reset values and timing counts of the port lock config block
//
// How it works
// (RULE1) Overcurrent threshold is full scale times field bits 2:0 over eight; reset all ones.
// (RULE2) Measurement period is (field bits 7:3 plus one) over 50 seconds; reset zero.
// (RULE3) Reference select bit 0 clear uses internal reference, set uses external one.
// (RULE4) While lock bit clear, three slave-select toggles switch the port to SPI.
// (RULE5) Host must write 1 to the lock bit to keep I2C selected.
// (RULE6) Once I2C lock is set, slave-select toggles are ignored; SPI never selected.
// (RULE7) With SPI active, any write to the second register locks SPI permanently.
// (RULE8) Locked port choice is kept across power mode transitions.
// (RULE9) Second register bits 7:2 are reserved, reset zero, and control nothing.
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

`define PLC_ADDR_W            16
`define PLC_OFS_LEVEL         16'hEC00
`define PLC_OFS_CONFIG        16'hEC01
`define PLC_THR_LSB           0
`define PLC_THR_MSB           2
`define PLC_LINE_LSB          3
`define PLC_LINE_MSB          7
`define PLC_EXTREF_BIT        0
`define PLC_LOCK_BIT          1
`define PLC_THR_RST           3'h7
`define PLC_LINE_RST          5'h00
`define PLC_LEVEL_RST         8'h07
`define PLC_CONFIG_RST        8'h00
`define PLC_TOGGLES_TO_SPI    2'h3
`define PLC_PERIOD_DIV        50
`define PLC_CLK_HZ            100000000
`define PLC_TICKS_PER_LINE    (`PLC_CLK_HZ / `PLC_PERIOD_DIV)

`endif

/* File: plc_pkg.sv */
// Types of the port lock config block
package plc_pkg;
	// Serial port selection, Gray coded along I2C -> SPI -> locked SPI
	typedef enum logic [1:0] {
		PLC_I2C      = 2'h0,
		PLC_SPI      = 2'h1,
		PLC_SPI_LOCK = 2'h3,
		PLC_I2C_LOCK = 2'h2
	} plc_port_t;
endpackage

/* File: plc_period_timer.sv */
// Low-power measurement period timer producing one pulse per period
`timescale 1ns/1ps
`default_nettype none
`include "plc_defs.svh"
module plc_period_timer #(
	parameter int TICKS_PER_LINE = `PLC_TICKS_PER_LINE
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Period setting
	input  wire logic [4:0] line_val,
	// Period end
	output var  logic       period_end
);
	logic [31:0] tick_r, tick_nxt;
	logic [5:0]  line_r, line_nxt;
	logic        end_nxt;

	// ------------------------------------------------------------
	// Period = (line + 1) steps of 1/50 s
	// ------------------------------------------------------------
	always_comb begin
		tick_nxt = tick_r + 32'h1;
		line_nxt = line_r;
		end_nxt  = 1'b0;
		if (tick_r >= 32'(TICKS_PER_LINE - 1)) begin
			tick_nxt = 32'h0;
			if (line_r >= {1'b0, line_val}) begin  // [RULE2]
				line_nxt = 6'h00;
				end_nxt  = 1'b1;
			end else begin
				line_nxt = line_r + 6'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_r     <= 32'h0;
			line_r     <= 6'h00;
			period_end <= 1'b0;
		end else begin
			tick_r     <= tick_nxt;
			line_r     <= line_nxt;
			period_end <= end_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: plc_regs.sv */
// Overcurrent level and reference / port lock configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "plc_defs.svh"
module plc_regs
	import plc_pkg::*;
#(
	parameter int TICKS_PER_LINE = `PLC_TICKS_PER_LINE
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// Register access from the active serial port
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [`PLC_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	output var  logic [7:0]             reg_rdata,
	// Slave-select pin level, synchronous to clk
	input  wire logic                   slave_select_or_capture_active_pin,
	// Power mode state, carried only for visibility
	input  wire logic [1:0]             power_mode_state,
	// Configuration outputs
	output var  logic [2:0]             overcurrent_threshold_field,
	output var  logic [4:0]             measure_period_field,
	output var  logic                   external_reference_select,
	output var  logic                   spi_selected,
	output var  logic                   port_locked,
	output var  logic                   period_end
);
	logic [7:0] level_r, level_nxt;
	logic       extref_r, extref_nxt;
	logic       lockbit_r, lockbit_nxt;
	plc_port_t  port_r, port_nxt;
	logic [1:0] tog_r, tog_nxt;
	logic       ss_d_r;
	logic [7:0] rdata_nxt;
	logic       wr_level, wr_config, ss_edge, period_pulse;
	logic [2:0] thr_out_nxt;
	logic [4:0] line_out_nxt;
	logic       ext_out_nxt, spi_out_nxt, lock_out_nxt, pe_out_nxt;

	assign wr_level  = reg_wr && (reg_addr == `PLC_OFS_LEVEL);
	assign wr_config = reg_wr && (reg_addr == `PLC_OFS_CONFIG);
	// Any edge counts as a toggle
	assign ss_edge   = slave_select_or_capture_active_pin ^ ss_d_r;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_comb begin
		level_nxt   = level_r;
		extref_nxt  = extref_r;
		lockbit_nxt = lockbit_r;
		if (wr_level) begin
			level_nxt = reg_wdata;  // [RULE1] [RULE2]
		end
		if (wr_config) begin
			extref_nxt  = reg_wdata[`PLC_EXTREF_BIT];  // [RULE3]
			// Lock bit is sticky: once set it never clears short of reset
			lockbit_nxt = lockbit_r | reg_wdata[`PLC_LOCK_BIT];  // [RULE5]
			// Bits 7:2 are dropped and read as zero [RULE9]
		end
	end

	// ------------------------------------------------------------
	// Port selection; power mode input deliberately unused here
	// ------------------------------------------------------------
	always_comb begin
		port_nxt = port_r;  // [RULE8]
		tog_nxt  = tog_r;
		case (port_r)
			PLC_I2C: begin
				if (wr_config && reg_wdata[`PLC_LOCK_BIT]) begin
					port_nxt = PLC_I2C_LOCK;  // [RULE6]
				end else if (ss_edge && !lockbit_r) begin  // [RULE4]
					if (tog_r == (`PLC_TOGGLES_TO_SPI - 2'h1)) begin
						port_nxt = PLC_SPI;
						tog_nxt  = 2'h0;
					end else begin
						tog_nxt = tog_r + 2'h1;
					end
				end
			end
			PLC_SPI: begin
				if (wr_config) begin
					port_nxt = PLC_SPI_LOCK;  // [RULE7]
				end
			end
			PLC_SPI_LOCK: port_nxt = PLC_SPI_LOCK;  // [RULE7]
			PLC_I2C_LOCK: port_nxt = PLC_I2C_LOCK;  // [RULE6]
			default:      port_nxt = PLC_I2C;
		endcase
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd && reg_addr == `PLC_OFS_LEVEL) begin
			rdata_nxt = level_r;
		end else if (reg_rd && reg_addr == `PLC_OFS_CONFIG) begin
			rdata_nxt = {6'h00, lockbit_r, extref_r};  // [RULE9]
		end
	end

	// ------------------------------------------------------------
	// Register file state
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			level_r   <= `PLC_LEVEL_RST;  // [RULE1] [RULE2]
			extref_r  <= 1'b0;
			lockbit_r <= 1'b0;
		end else begin
			level_r   <= level_nxt;
			extref_r  <= extref_nxt;
			lockbit_r <= lockbit_nxt;
		end
	end

	// ------------------------------------------------------------
	// Port selection state
	// ------------------------------------------------------------
	// Pin history resets to the idle high level, so a quiet pin gives no toggle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_r <= PLC_I2C;
			tog_r  <= 2'h0;
			ss_d_r <= 1'b1;
		end else begin
			port_r <= port_nxt;
			tog_r  <= tog_nxt;
			ss_d_r <= slave_select_or_capture_active_pin;
		end
	end

	// ------------------------------------------------------------
	// Read data state
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	// One more flop per output keeps the pins glitch free at the cost of a cycle
	always_comb begin
		thr_out_nxt  = level_r[`PLC_THR_MSB:`PLC_THR_LSB];  // [RULE1]
		line_out_nxt = level_r[`PLC_LINE_MSB:`PLC_LINE_LSB];  // [RULE2]
		ext_out_nxt  = extref_r;  // [RULE3]
		spi_out_nxt  = (port_r == PLC_SPI) || (port_r == PLC_SPI_LOCK);
		lock_out_nxt = (port_r == PLC_SPI_LOCK) || (port_r == PLC_I2C_LOCK);  // [RULE8]
		pe_out_nxt   = period_pulse;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			overcurrent_threshold_field <= `PLC_THR_RST;
			measure_period_field        <= `PLC_LINE_RST;
			external_reference_select   <= 1'b0;
			spi_selected                <= 1'b0;
			port_locked                 <= 1'b0;
			period_end                  <= 1'b0;
		end else begin
			overcurrent_threshold_field <= thr_out_nxt;
			measure_period_field        <= line_out_nxt;
			external_reference_select   <= ext_out_nxt;
			spi_selected                <= spi_out_nxt;
			port_locked                 <= lock_out_nxt;
			period_end                  <= pe_out_nxt;
		end
	end

	plc_period_timer #(
		.TICKS_PER_LINE(TICKS_PER_LINE)
	) u_timer (
		.clk       (clk),
		.rstn      (rstn),
		.line_val  (level_r[`PLC_LINE_MSB:`PLC_LINE_LSB]),
		.period_end(period_pulse)
	);
endmodule
`default_nettype wire

/* File: plc_regs_properties.sv */
// Concurrent checks on the port lock config registers
`timescale 1ns/1ps
`default_nettype none
`include "plc_defs.svh"
module plc_regs_properties #(
	parameter int TICKS_PER_LINE = `PLC_TICKS_PER_LINE
) (
	// Clock, reset and writes
	input wire logic                   clk,
	input wire logic                   rstn,
	input wire logic                   reg_wr,
	input wire logic [`PLC_ADDR_W-1:0] reg_addr,
	input wire logic [7:0]             reg_wdata,
	// Outputs
	input wire logic [2:0]             overcurrent_threshold_field,
	input wire logic [4:0]             measure_period_field,
	input wire logic                   external_reference_select,
	input wire logic                   spi_selected,
	input wire logic                   port_locked
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence lvl_wr; reg_wr && reg_addr == `PLC_OFS_LEVEL; endsequence
	sequence cfg_wr; reg_wr && reg_addr == `PLC_OFS_CONFIG; endsequence
	thr_follow_a: assert property (lvl_wr |-> ##2
		overcurrent_threshold_field == $past(reg_wdata[2:0], 2)) else $error("bad thr");
	line_follow_a: assert property (lvl_wr |-> ##2
		measure_period_field == $past(reg_wdata[7:3], 2)) else $error("bad line");
	ref_follow_a: assert property (cfg_wr |-> ##2
		external_reference_select == $past(reg_wdata[0], 2)) else $error("bad ref");
	lock_sticky_a: assert property (port_locked |=> port_locked)
		else $error("lock lost");
	i2c_hold_a: assert property (port_locked && !spi_selected |=> !spi_selected)
		else $error("left i2c");
	spi_hold_a: assert property (port_locked && spi_selected |=> spi_selected)
		else $error("left spi");
	spi_lock_a: assert property (cfg_wr ##0 spi_selected |-> ##2 port_locked)
		else $error("spi not locked");
	i2c_lock_a: assert property (cfg_wr ##0 reg_wdata[1] && !spi_selected |->
		##2 port_locked && !spi_selected) else $error("i2c not locked");
endmodule
bind plc_regs plc_regs_properties #(.TICKS_PER_LINE(TICKS_PER_LINE)) chk (.clk, .rstn,
	.reg_wr, .reg_addr, .reg_wdata, .overcurrent_threshold_field, .measure_period_field,
	.external_reference_select, .spi_selected, .port_locked);
`default_nettype wire

/* File: plc_host.sv */
// Host model: register accesses and slave-select toggles
`timescale 1ns/1ps
`default_nettype none
module plc_host (
	// Clock
	input  wire logic        clk,
	// Access and pin
	output var  logic        wr,
	output var  logic        rd,
	output var  logic [15:0] addr,
	output var  logic [7:0]  wd,
	output var  logic        pin
);
	initial {wr, rd, addr, wd, pin} = {2'h0, 16'h0000, 8'h00, 1'h1};
	// Released bus shows inverted values so stale data never looks valid
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		{wr, rd, addr, wd} <= {w, !w, a, d};
		@(posedge clk);
		{wr, rd, addr, wd} <= {2'h0, ~a, ~d};
	endtask
	task automatic tog();
		@(posedge clk);
		pin <= !pin;
	endtask
endmodule
`default_nettype wire

/* File: port_lock_config_regs_bench.sv */
// Self-checking bench of the port lock config registers
`timescale 1ns/1ps
`default_nettype none
`include "plc_defs.svh"
module port_lock_config_regs_bench;
	localparam int TP = 10;
	logic        clk = 1'h0, rstn = 1'h0, rd_seen = 1'h0;
	logic        wr, rd, pin, spi, lck, ext, pe;
	logic [1:0]  pm = 2'h0;
	logic [15:0] addr;
	logic [7:0]  wd, rdata, v;
	logic [2:0]  thr;
	logic [4:0]  line;
	logic [7:0]  q[$];
	int          bad_count = 0, n_tests = 0, n;
	initial forever #5 clk = !clk;
	plc_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wd(wd), .pin(pin));
	plc_regs #(.TICKS_PER_LINE(TP)) dut (.clk(clk), .rstn(rstn), .reg_wr(wr), .reg_rd(rd),
		.reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
		.slave_select_or_capture_active_pin(pin), .power_mode_state(pm),
		.overcurrent_threshold_field(thr), .measure_period_field(line),
		.external_reference_select(ext), .spi_selected(spi), .port_locked(lck), .period_end(pe));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	always @(posedge clk) begin
		if (rd_seen)
			chk(rdata, q.pop_front());
		rd_seen <= rd;
	end
	task automatic rdq(input logic [15:0] a, input logic [7:0] e);
		q.push_back(e);
		host.acc(1'h0, a, 8'h00);
	endtask
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rst();
		@(posedge clk);
		rstn <= 1'h0;
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
	endtask
	task automatic tick();
		n = 0;
		do begin @(posedge clk); n++; end while (pe !== 1'h1 && n < 400);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Run takes about 120 cycles; the limit leaves ample margin
	initial begin #60000; bad_count++; close_out(); end
	initial begin
		n = $urandom(39);
		rst();
		settle();
		chk({line, thr}, `PLC_LEVEL_RST);
		chk({5'h00, ext, spi, lck}, 8'h00);
		rdq(`PLC_OFS_CONFIG, `PLC_CONFIG_RST);
		rdq(16'hEC02, 8'h00);
		repeat (4) begin
			v = 8'($urandom);
			host.acc(1'h1, `PLC_OFS_LEVEL, v);
			rdq(`PLC_OFS_LEVEL, v);
			settle();
			chk({line, thr}, v);
		end
		host.acc(1'h1, `PLC_OFS_LEVEL, 8'h0B);
		tick();
		tick();
		chk(8'(n), 8'(2 * TP));
		v = 8'($urandom) & 8'hFD;
		host.acc(1'h1, `PLC_OFS_CONFIG, v);
		rdq(`PLC_OFS_CONFIG, v & 8'h01);
		settle();
		chk({5'h00, ext, spi, lck}, {5'h00, v[0], 2'h0});
		host.acc(1'h1, `PLC_OFS_CONFIG, 8'h02);
		repeat (4) begin host.tog(); pm <= pm + 2'h1; end
		settle();
		chk({5'h00, ext, spi, lck}, 8'h01);
		rst();
		repeat (2) host.tog();
		settle();
		chk({5'h00, ext, spi, lck}, 8'h00);
		host.tog();
		settle();
		chk({5'h00, ext, spi, lck}, 8'h02);
		host.acc(1'h1, `PLC_OFS_CONFIG, 8'h00);
		repeat (3) begin host.tog(); pm <= pm + 2'h1; end
		settle();
		chk({5'h00, ext, spi, lck}, 8'h03);
		close_out();
	end
endmodule
`default_nettype wire
